//--- inc/perf_pkg.sv
/*
  shared constants and carrier types of the performance event counting unit.
  assumes a 12-bit word-aligned register window and a 51-bit event strobe bus.
*/
package perf_pkg;
  localparam int NUM_CNT = 8;
  localparam int EVT_W = 16;
  localparam int CYC_W = 32;
  localparam int EVT_BUS_W = 51;
  localparam int ADDR_W = 12;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef struct packed {
    logic valid;
    logic [NUM_CNT-1:0] flags;
  } trace_pkt_t;

  // register byte offsets inside the window
  localparam logic [ADDR_W-1:0] EVCNTR_BASE = 12'h000;
  localparam logic [ADDR_W-1:0] CCNTR_OFF = 12'h07c;
  localparam logic [ADDR_W-1:0] EVTYPER_BASE = 12'h400;
  localparam logic [ADDR_W-1:0] CNTENSET_OFF = 12'hc00;
  localparam logic [ADDR_W-1:0] CNTENCLR_OFF = 12'hc20;
  localparam logic [ADDR_W-1:0] INTENSET_OFF = 12'hc40;
  localparam logic [ADDR_W-1:0] INTENCLR_OFF = 12'hc60;
  localparam logic [ADDR_W-1:0] OVSCLR_OFF = 12'hc80;
  localparam logic [ADDR_W-1:0] SWINC_OFF = 12'hca0;
  localparam logic [ADDR_W-1:0] OVSSET_OFF = 12'hcc0;
  localparam logic [ADDR_W-1:0] WATCH_CTRL_OFF = 12'hf00;
  localparam logic [ADDR_W-1:0] DEBUG_CTRL_OFF = 12'hf04;

  // valid bits of enable, interrupt-enable and overflow masks
  localparam logic [31:0] CNT_MASK = 32'h8000_00ff;
  localparam int CYC_BIT = 31;
  localparam logic [31:0] MASK_RESET = 32'h0000_0000;

  // watch control fields
  localparam int WC_CYC_EN = 0;
  localparam int WC_PROF_MODE = 1;
  localparam int WC_NO_CYC = 2;
  // debug control fields
  localparam int DC_MON_EN = 0;
  localparam int DC_MON_PEND = 1;
  localparam int DC_HALT_EN = 2;
  localparam int DC_FAULT_CAUSE = 3;

  // event codes and their strobe bus bits
  localparam logic [EVT_W-1:0] EV_SOFT_INC = 16'h0000;
  localparam logic [EVT_W-1:0] EV_ICACHE_FILL = 16'h0001;
  localparam logic [EVT_W-1:0] EV_DCACHE_FILL = 16'h0003;
  localparam logic [EVT_W-1:0] EV_DCACHE_ACC = 16'h0004;
  localparam logic [EVT_W-1:0] EV_LOAD_RET = 16'h0006;
  localparam logic [EVT_W-1:0] EV_STORE_RET = 16'h0007;
  localparam logic [EVT_W-1:0] EV_INSTR_RET = 16'h0008;
  localparam logic [EVT_W-1:0] EV_CYCLES = 16'h0011;
  localparam logic [EVT_W-1:0] EV_BUS_BEAT = 16'h0019;
  localparam logic [EVT_W-1:0] EV_MEM_ERR = 16'h001a;
  localparam logic [EVT_W-1:0] EV_BUS_CYCLES = 16'h001d;
  localparam logic [EVT_W-1:0] EV_CHAIN = 16'h001e;
  localparam logic [EVT_W-1:0] EV_FETCH_STARVE = 16'h0023;
  localparam logic [EVT_W-1:0] EV_DECODE_BLOCK = 16'h0024;
  localparam logic [EVT_W-1:0] EV_NO_ISSUE = 16'h003c;
  localparam logic [EVT_W-1:0] EV_CMP_BASE = 16'h0118;
  localparam logic [EVT_W-1:0] EV_CMP_LAST = 16'h011b;

  localparam logic [5:0] BIT_SOFT_INC = 6'h00;
  localparam logic [5:0] BIT_ICACHE_FILL = 6'h01;
  localparam logic [5:0] BIT_DCACHE_FILL = 6'h02;
  localparam logic [5:0] BIT_DCACHE_ACC = 6'h03;
  localparam logic [5:0] BIT_LOAD_RET = 6'h04;
  localparam logic [5:0] BIT_STORE_RET = 6'h05;
  localparam logic [5:0] BIT_INSTR_RET = 6'h06;
  localparam logic [5:0] BIT_CYCLES = 6'h0e;
  localparam logic [5:0] BIT_BUS_BEAT = 6'h13;
  localparam logic [5:0] BIT_MEM_ERR = 6'h14;
  localparam logic [5:0] BIT_BUS_CYCLES = 6'h16;
  localparam logic [5:0] BIT_FETCH_STARVE = 6'h1b;
  localparam logic [5:0] BIT_DECODE_BLOCK = 6'h1c;
  localparam logic [5:0] BIT_NO_ISSUE = 6'h22;
  localparam logic [5:0] BIT_CMP_BASE = 6'h2f;
endpackage

//--- design/count_cell.sv
/*
  one wrapping up-counter with a load port and rollover strobes.
  assumes ld and inc are synchronous to clk; a load always beats an increment.
*/
`timescale 1ns/10ps
`default_nettype none
module count_cell #(
  parameter int W = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic inc,
  input wire logic ld,
  input wire logic [W-1:0] ld_val,
  output logic [W-1:0] value,
  output logic wrap,
  output logic byte_roll
);
  logic [W-1:0] cnt_ff;
  logic [W-1:0] nxt_cnt;
  logic step;

  // a load suppresses the step, so no strobe ever comes from a load
  assign step = inc & ~ld;
  assign wrap = step & (&cnt_ff);
  assign byte_roll = step & (&cnt_ff[7:0]);
  assign nxt_cnt = ld ? ld_val : (step ? cnt_ff + W'(1) : cnt_ff);
  assign value = cnt_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end
endmodule
`default_nettype wire

//--- design/event_pick.sv
/*
  maps an event code onto the strobe bus and returns that strobe.
  assumes strobes are one-cycle pulses or levels sampled every clk.
*/
`timescale 1ns/10ps
`default_nettype none
module event_pick
  import perf_pkg::*;
(
  input wire logic [EVT_W-1:0] code,
  input wire logic [EVT_BUS_W-1:0] evt_bus,
  output logic hit
);
  // returns {known, bus bit}
  function automatic logic [6:0] code_to_bit(input logic [EVT_W-1:0] c);
    logic [6:0] r;
    r = 7'h00;
    if (c == EV_SOFT_INC) r = {1'b1, BIT_SOFT_INC};
    else if (c == EV_ICACHE_FILL) r = {1'b1, BIT_ICACHE_FILL};
    else if (c == EV_DCACHE_FILL) r = {1'b1, BIT_DCACHE_FILL};
    else if (c == EV_DCACHE_ACC) r = {1'b1, BIT_DCACHE_ACC};
    else if (c == EV_LOAD_RET) r = {1'b1, BIT_LOAD_RET};
    else if (c == EV_STORE_RET) r = {1'b1, BIT_STORE_RET};
    else if (c == EV_INSTR_RET) r = {1'b1, BIT_INSTR_RET};
    else if (c == EV_CYCLES) r = {1'b1, BIT_CYCLES};
    else if (c == EV_BUS_BEAT) r = {1'b1, BIT_BUS_BEAT};
    else if (c == EV_MEM_ERR) r = {1'b1, BIT_MEM_ERR};
    else if (c == EV_BUS_CYCLES) r = {1'b1, BIT_BUS_CYCLES};
    else if (c == EV_FETCH_STARVE) r = {1'b1, BIT_FETCH_STARVE};
    else if (c == EV_DECODE_BLOCK) r = {1'b1, BIT_DECODE_BLOCK};
    else if (c == EV_NO_ISSUE) r = {1'b1, BIT_NO_ISSUE};
    else if (c >= EV_CMP_BASE && c <= EV_CMP_LAST) r = {1'b1, BIT_CMP_BASE + c[5:0] - EV_CMP_BASE[5:0]};
    return r;
  endfunction

  logic [6:0] sel;
  assign sel = code_to_bit(code);
  assign hit = sel[6] & evt_bus[sel[5:0]];
endmodule
`default_nettype wire

//--- design/perf_monitor.sv
/*
  performance event counting unit: eight 16-bit event counters, a shared
  32-bit cycle counter, overflow flags, monitor request, trace and trigger.
  assumes a single-cycle register port, event strobes synchronous to clk,
  and debug monitor logic that consumes the pend/cause levels outside.
*/
// The strobed register port and the register offsets were chosen for this implementation.
// Functional notes
// - eight 16-bit event counters and one 32-bit cycle counter
// - even/odd pair cascades to 32 bits; only odd counters chain
// - odd counter on chain code counts overflows of the even below
// - an event counter advances only while its enable bit is set
// - event counters are shared with watch unit profiling, one user at once
// - cycle counter is one register, enabled by either unit
// - with watch unit present the no-cycle-counter bit reads zero, ignores writes
// - enabled overflow sets monitor pend and fault cause; flag names counter
// - interrupt requested only with counter irq enable and monitor enable
// - low byte rollover emits a trace packet with that counter's flag
// - trace comes from increments only; several flags may share a packet
// - an event output feeds the cross trigger block
// - the unit exists only when the watch unit is present
// - code 0x0000 counts soft increments on event bus bit 0
// - codes 0x0001, 0x0003, 0x0004 count cache fills and data cache accesses
// - codes 0x0006, 0x0007, 0x0008 count retired loads, stores, instructions
// - code 0x0011 counts cycles, 0x001D counts bus-clocked cycles
// - code 0x0019 counts bus data beats and peripheral accesses
// - code 0x001A signals memory ecc errors
// - codes 0x0023 and 0x0024 count fetch starve and decode block cycles
// - code 0x003C counts cycles with no operation issued
// - codes 0x0118 to 0x011B count comparator zero to three hits
// - optionally request debug halt on irq-enabled overflow
`timescale 1ns/10ps
`default_nettype none
module perf_monitor
  import perf_pkg::*;
#(
  parameter bit WATCH_PRESENT = 1'b1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire reg_req_t bus_req,
  output logic [31:0] rdata,
  input wire logic [EVT_BUS_W-1:0] evt_bus,
  input wire logic [NUM_CNT-1:0] watch_prof_evt,
  output logic monitor_pend_bit,
  output logic fault_cause_counter_bit,
  output logic halt_req,
  output var trace_pkt_t trace_pkt,
  output logic trigger_evt
);
  logic [31:0] cnt_en_ff;
  logic [31:0] irq_en_ff;
  logic [31:0] ovs_ff;
  logic [EVT_W-1:0] evt_type_ff [NUM_CNT];
  logic watch_cyc_en_ff;
  logic watch_prof_ff;
  logic mon_en_ff;
  logic pend_ff;
  logic cause_ff;
  logic halt_en_ff;
  logic halt_ff;
  logic [31:0] rdata_ff;
  trace_pkt_t trace_ff;
  logic trig_ff;

  logic [EVT_W-1:0] evt_val [NUM_CNT];
  logic [NUM_CNT-1:0] evt_wrap;
  logic [NUM_CNT-1:0] evt_roll;
  logic [NUM_CNT-1:0] evt_inc;
  logic [NUM_CNT-1:0] evt_ld;
  logic [NUM_CNT-1:0] sel_hit;
  logic [NUM_CNT-1:0] soft_hit;
  logic [CYC_W-1:0] cyc_val;
  logic cyc_wrap;
  logic cyc_inc;
  logic cyc_ld;
  logic [31:0] hw_ovf;
  logic irq_hit;
  logic irq_req;
  logic [31:0] rd_val;

  // address decode
  logic wr;
  logic [ADDR_W-1:0] a;
  logic [31:0] wd;
  logic in_cnt_bank;
  logic in_type_bank;
  logic [2:0] bank_idx;
  logic wr_enset;
  logic wr_enclr;
  logic wr_irqset;
  logic wr_irqclr;
  logic wr_ovsclr;
  logic wr_ovsset;
  logic wr_swinc;
  logic wr_watch;
  logic wr_debug;

  assign wr = bus_req.wr & WATCH_PRESENT;
  assign a = bus_req.addr;
  assign wd = bus_req.wdata;
  assign in_cnt_bank = (a[ADDR_W-1:5] == EVCNTR_BASE[ADDR_W-1:5]);
  assign in_type_bank = (a[ADDR_W-1:5] == EVTYPER_BASE[ADDR_W-1:5]);
  assign bank_idx = a[4:2];
  assign wr_enset = wr & (a == CNTENSET_OFF);
  assign wr_enclr = wr & (a == CNTENCLR_OFF);
  assign wr_irqset = wr & (a == INTENSET_OFF);
  assign wr_irqclr = wr & (a == INTENCLR_OFF);
  assign wr_ovsclr = wr & (a == OVSCLR_OFF);
  assign wr_ovsset = wr & (a == OVSSET_OFF);
  assign wr_swinc = wr & (a == SWINC_OFF);
  assign wr_watch = wr & (a == WATCH_CTRL_OFF);
  assign wr_debug = wr & (a == DEBUG_CTRL_OFF);
  assign cyc_ld = wr & (a == CCNTR_OFF);

  // counters
  genvar i;
  generate
    for (i = 0; i < NUM_CNT; i++) begin : g_cnt
      logic base_inc;
      assign evt_ld[i] = wr & in_cnt_bank & (bank_idx == 3'(i));
      assign soft_hit[i] = wr_swinc & wd[i] & (evt_type_ff[i] == EV_SOFT_INC);
      event_pick u_pick (
        .code(evt_type_ff[i]),
        .evt_bus(evt_bus),
        .hit(sel_hit[i])
      );
      if (i % 2 == 1) begin : g_odd
        // chain feeds straight from the lower wrap, same cycle, no lag
        assign base_inc = (evt_type_ff[i] == EV_CHAIN) ? evt_wrap[i-1] : (sel_hit[i] | soft_hit[i]);
      end else begin : g_even
        assign base_inc = (evt_type_ff[i] == EV_CHAIN) ? 1'b0 : (sel_hit[i] | soft_hit[i]);
      end
      // profiling mode hands the same flops to the watch unit
      assign evt_inc[i] = WATCH_PRESENT & cnt_en_ff[i] & (watch_prof_ff ? watch_prof_evt[i] : base_inc);
      count_cell #(.W(EVT_W)) u_cnt (
        .clk(clk),
        .rst_n(rst_n),
        .inc(evt_inc[i]),
        .ld(evt_ld[i]),
        .ld_val(wd[EVT_W-1:0]),
        .value(evt_val[i]),
        .wrap(evt_wrap[i]),
        .byte_roll(evt_roll[i])
      );
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          evt_type_ff[i] <= '0;
        end else if (wr & in_type_bank & (bank_idx == 3'(i))) begin
          evt_type_ff[i] <= wd[EVT_W-1:0];
        end
      end
    end
  endgenerate

  assign cyc_inc = WATCH_PRESENT & (cnt_en_ff[CYC_BIT] | watch_cyc_en_ff);
  count_cell #(.W(CYC_W)) u_cyc (
    .clk(clk),
    .rst_n(rst_n),
    .inc(cyc_inc),
    .ld(cyc_ld),
    .ld_val(wd),
    .value(cyc_val),
    .wrap(cyc_wrap),
    .byte_roll()
  );

  // overflow and monitor request
  assign hw_ovf = {cyc_wrap, 23'h000000, evt_wrap};
  assign irq_hit = |(hw_ovf & irq_en_ff);
  assign irq_req = irq_hit & mon_en_ff;

  // set from hardware wins over a same-cycle clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ovs_ff <= MASK_RESET;
    end else begin
      ovs_ff <= ((ovs_ff & ~(wr_ovsclr ? wd : 32'h0)) | (wr_ovsset ? wd : 32'h0) | hw_ovf) & CNT_MASK;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_en_ff <= MASK_RESET;
      irq_en_ff <= MASK_RESET;
    end else begin
      cnt_en_ff <= ((cnt_en_ff | (wr_enset ? wd : 32'h0)) & ~(wr_enclr ? wd : 32'h0)) & CNT_MASK;
      irq_en_ff <= ((irq_en_ff | (wr_irqset ? wd : 32'h0)) & ~(wr_irqclr ? wd : 32'h0)) & CNT_MASK;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      watch_cyc_en_ff <= 1'b0;
      watch_prof_ff <= 1'b0;
    end else if (wr_watch) begin
      watch_cyc_en_ff <= wd[WC_CYC_EN];
      watch_prof_ff <= wd[WC_PROF_MODE];
    end
  end

  // pend and cause are write-one-to-clear; a new request wins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mon_en_ff <= 1'b0;
      halt_en_ff <= 1'b0;
      pend_ff <= 1'b0;
      cause_ff <= 1'b0;
    end else begin
      if (wr_debug) begin
        mon_en_ff <= wd[DC_MON_EN];
        halt_en_ff <= wd[DC_HALT_EN];
      end
      pend_ff <= (pend_ff & ~(wr_debug & wd[DC_MON_PEND])) | irq_req;
      cause_ff <= (cause_ff & ~(wr_debug & wd[DC_FAULT_CAUSE])) | irq_req;
    end
  end

  // halt request does not need the monitor enabled, only the irq enable and the halt enable
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      halt_ff <= 1'b0;
      trace_ff <= '0;
      trig_ff <= 1'b0;
    end else begin
      halt_ff <= irq_hit & halt_en_ff;
      trace_ff.valid <= |evt_roll;
      trace_ff.flags <= evt_roll;
      trig_ff <= |hw_ovf;
    end
  end

  // register read, answered one cycle later
  always_comb begin
    rd_val = 32'h0;
    if (!WATCH_PRESENT) begin
      rd_val = 32'h0;
    end else if (in_cnt_bank) begin
      rd_val = {16'h0, evt_val[bank_idx]};
    end else if (a == CCNTR_OFF) begin
      rd_val = cyc_val;
    end else if (in_type_bank) begin
      rd_val = {16'h0, evt_type_ff[bank_idx]};
    end else if (a == CNTENSET_OFF || a == CNTENCLR_OFF) begin
      rd_val = cnt_en_ff;
    end else if (a == INTENSET_OFF || a == INTENCLR_OFF) begin
      rd_val = irq_en_ff;
    end else if (a == OVSSET_OFF || a == OVSCLR_OFF) begin
      rd_val = ovs_ff;
    end else if (a == WATCH_CTRL_OFF) begin
      rd_val[WC_CYC_EN] = watch_cyc_en_ff;
      rd_val[WC_PROF_MODE] = watch_prof_ff;
      rd_val[WC_NO_CYC] = 1'b0;
    end else if (a == DEBUG_CTRL_OFF) begin
      rd_val[DC_MON_EN] = mon_en_ff;
      rd_val[DC_MON_PEND] = pend_ff;
      rd_val[DC_HALT_EN] = halt_en_ff;
      rd_val[DC_FAULT_CAUSE] = cause_ff;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff <= 32'h0;
    end else if (bus_req.rd) begin
      rdata_ff <= rd_val;
    end else begin
      rdata_ff <= 32'h0;
    end
  end

  assign rdata = rdata_ff;
  assign monitor_pend_bit = pend_ff;
  assign fault_cause_counter_bit = cause_ff;
  assign halt_req = halt_ff;
  assign trace_pkt = trace_ff;
  assign trigger_evt = trig_ff;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  hold_when_off_a: assert property (!cnt_en_ff[0] && !evt_ld[0] |=> $stable(evt_val[0]))
    else $error("counter 0 moved while disabled");
  chain_step_a: assert property (evt_wrap[0] && cnt_en_ff[1] && !watch_prof_ff &&
    evt_type_ff[1] == EV_CHAIN && !evt_ld[1] |=> evt_val[1] == $past(evt_val[1]) + 16'h1)
    else $error("chained counter missed lower overflow");
  even_no_chain_a: assert property (evt_type_ff[0] == EV_CHAIN && !watch_prof_ff &&
    !evt_ld[0] |=> $stable(evt_val[0]))
    else $error("even counter acted on chain code");
  wrap_zero_a: assert property (evt_wrap[0] |=> evt_val[0] == 16'h0 && ovs_ff[0])
    else $error("overflow did not wrap and flag");
  pend_set_a: assert property (irq_req |=> monitor_pend_bit && fault_cause_counter_bit)
    else $error("monitor request not pended");
  irq_gate_a: assert property (!mon_en_ff |=> $stable(pend_ff) || $fell(pend_ff))
    else $error("pend set without monitor enable");
  trace_roll_a: assert property (evt_roll[0] |=> trace_pkt.valid && trace_pkt.flags[0])
    else $error("byte rollover gave no trace packet");
  no_trace_wr_a: assert property (evt_ld[0] |=> !trace_pkt.flags[0])
    else $error("software write produced trace");
  cyc_shared_a: assert property (watch_cyc_en_ff && !cyc_ld |=> cyc_val == $past(cyc_val) + 32'h1)
    else $error("cycle counter idle under watch enable");
  no_cyc_flag_a: assert property (bus_req.rd && a == WATCH_CTRL_OFF |=> !rdata[WC_NO_CYC])
    else $error("no-cycle-counter bit read as one");
  trig_out_a: assert property (|hw_ovf |=> trigger_evt)
    else $error("overflow gave no trigger");
  // stepping, sticky state and quiet outputs
  count_step_a: assert property (cnt_en_ff[0] && !watch_prof_ff && !evt_ld[0] &&
    evt_type_ff[0] != EV_CHAIN && sel_hit[0] |=> evt_val[0] == $past(evt_val[0]) + 16'h1)
    else $error("enabled counter missed its event");
  flag_sticky_a: assert property (ovs_ff[0] && !(wr_ovsclr && wd[0]) |=> ovs_ff[0])
    else $error("overflow flag lost without clear");
  pend_hold_a: assert property (pend_ff && !(wr_debug && wd[DC_MON_PEND]) |=> pend_ff)
    else $error("monitor pend lost without clear");
  irq_mask_a: assert property (!irq_hit |=> $stable(pend_ff) || $fell(pend_ff))
    else $error("pend set without irq enable");
  halt_gate_a: assert property (!irq_hit |=> !halt_req)
    else $error("halt request without enabled overflow");
  trace_quiet_a: assert property (!(|evt_roll) |=> !trace_pkt.valid)
    else $error("trace packet without rollover");
  roll_four_a: assert property (evt_roll[4] |=> trace_pkt.flags[4])
    else $error("counter 4 rollover missing from trace");
  trig_quiet_a: assert property (!(|hw_ovf) |=> !trigger_evt)
    else $error("trigger without overflow");
  prof_step_a: assert property (watch_prof_ff && cnt_en_ff[6] && !evt_ld[6] &&
    watch_prof_evt[6] |=> evt_val[6] == $past(evt_val[6]) + 16'h1)
    else $error("profiling strobe not counted");
  soft_step_a: assert property (soft_hit[3] && cnt_en_ff[3] && !watch_prof_ff &&
    !evt_ld[3] |=> evt_val[3] == $past(evt_val[3]) + 16'h1)
    else $error("software increment not counted");
  cyc_hold_a: assert property (!cnt_en_ff[CYC_BIT] && !watch_cyc_en_ff && !cyc_ld
    |=> $stable(cyc_val))
    else $error("cycle counter moved while off");
  cyc_wrap_a: assert property (cyc_wrap |=> cyc_val == 32'h0 && ovs_ff[CYC_BIT])
    else $error("cycle counter overflow lost");

  chain_ovf_c: cover property (evt_wrap[0] && evt_type_ff[1] == EV_CHAIN && cnt_en_ff[1]);
  irq_req_c: cover property (irq_req ##1 monitor_pend_bit);
  multi_flag_c: cover property (trace_pkt.valid && !$onehot(trace_pkt.flags));
  halt_req_c: cover property (halt_req);
  prof_count_c: cover property (watch_prof_ff && evt_inc[6]);
endmodule
`default_nettype wire

//--- dv/evt_source.sv
/*
  event source model: core strobes and watch-unit profiling strobes.
  assumes the bench sets want_evt and want_prof just after clk rises.
*/
`timescale 1ns/10ps
`default_nettype none
module evt_source
  import perf_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [EVT_BUS_W-1:0] want_evt,
  input wire logic [NUM_CNT-1:0] want_prof,
  output logic [EVT_BUS_W-1:0] evt_bus,
  output logic [NUM_CNT-1:0] watch_prof_evt
);
  // one register stage, as a pipeline flop would give; a held want counts every cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      evt_bus <= '0;
      watch_prof_evt <= '0;
    end else begin
      evt_bus <= want_evt;
      watch_prof_evt <= want_prof;
    end
  end
endmodule
`default_nettype wire

//--- dv/tb_top.sv
/*
  self-checking bench of the performance event counting unit.
  assumes the single-cycle register port and the default watch-present build.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import perf_pkg::*;
;
  logic clk, rst_n, pend, cause, halt_req, trigger_evt;
  reg_req_t bus_req;
  logic [31:0] rdata, rv, c0;
  logic [EVT_BUS_W-1:0] want_evt, evt_bus, m;
  logic [NUM_CNT-1:0] want_prof, watch_prof_evt;
  trace_pkt_t trace_pkt;
  int n_mismatch, samples_checked, hits, b;
  logic [15:0] codes[20] = '{16'h0000, 16'h0001, 16'h0003, 16'h0004, 16'h0006, 16'h0007,
    16'h0008, 16'h0011, 16'h0019, 16'h001a, 16'h001d, 16'h0023, 16'h0024, 16'h003c,
    16'h0118, 16'h0119, 16'h011a, 16'h011b, 16'h001e, 16'h0002};

  perf_monitor u_perf_monitor (.clk(clk), .rst_n(rst_n), .bus_req(bus_req), .rdata(rdata),
    .evt_bus(evt_bus), .watch_prof_evt(watch_prof_evt), .monitor_pend_bit(pend),
    .fault_cause_counter_bit(cause), .halt_req(halt_req), .trace_pkt(trace_pkt),
    .trigger_evt(trigger_evt));
  evt_source u_evt_source (.clk(clk), .rst_n(rst_n), .want_evt(want_evt),
    .want_prof(want_prof), .evt_bus(evt_bus), .watch_prof_evt(watch_prof_evt));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // strobe bit of each code; the chain code and unknown codes give -1 and never count
  function automatic int bit_of(input logic [15:0] c);
    case (c)
      16'h0000: return 0;
      16'h0001: return 1;
      16'h0003: return 2;
      16'h0004: return 3;
      16'h0006: return 4;
      16'h0007: return 5;
      16'h0008: return 6;
      16'h0011: return 14;
      16'h0019: return 19;
      16'h001a: return 20;
      16'h001d: return 22;
      16'h0023: return 27;
      16'h0024: return 28;
      16'h003c: return 34;
      default: return (c >= 16'h0118 && c <= 16'h011b) ? 47 + int'(c - 16'h0118) : -1;
    endcase
  endfunction

  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus_req.wr <= 1'b0;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] d);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus_req.rd <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic rchk(input logic [ADDR_W-1:0] a, input logic [31:0] e, input string w);
    rd(a, rv);
    chk(rv, e, w);
  endtask

  // one strobe cycle; returns once the overflow outputs of that strobe stand
  task automatic pulse(input logic [EVT_BUS_W-1:0] s, input logic [NUM_CNT-1:0] p);
    @(posedge clk);
    want_evt <= s;
    want_prof <= p;
    @(posedge clk);
    want_evt <= '0;
    want_prof <= '0;
    @(posedge clk);
    #1;
  endtask

  // cycle counter advance between two reads taken 12 edges apart
  task automatic cyc_diff(output logic [31:0] d);
    rd(CCNTR_OFF, c0);
    repeat (10) @(posedge clk);
    rd(CCNTR_OFF, d);
    d = d - c0;
  endtask

  initial begin
    #100us;
    n_mismatch++;
    $display("[FAIL] %0t watchdog expired", $time);
    close_out();
  end

  initial begin
    bus_req = '0;
    want_evt = '0;
    want_prof = '0;
    n_mismatch = 0;
    samples_checked = 0;
    rst_n = 1'b0;
    void'($urandom(20735));
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    chk(32'({pend, cause, halt_req, trigger_evt, trace_pkt.valid}), 32'h0, "reset outs");
    rchk(CNTENSET_OFF, 32'h0, "enable reset");
    rchk(OVSSET_OFF, 32'h0, "flags reset");
    rchk(EVCNTR_BASE + 12'h1c, 32'h0, "counter reset");
    wr(WATCH_CTRL_OFF, 32'h4);
    rchk(WATCH_CTRL_OFF, 32'h0, "no-cycle bit");
    rchk(12'h800, 32'h0, "unmapped read");
    $display("test reset done");
    // every code on counter 0 with random strobe traffic on all bits
    wr(CNTENSET_OFF, 32'h1);
    foreach (codes[i]) begin
      wr(EVTYPER_BASE, {16'h0, codes[i]});
      wr(EVCNTR_BASE, 32'h0);
      hits = 0;
      b = bit_of(codes[i]);
      repeat (6) begin
        m = EVT_BUS_W'({$urandom, $urandom});
        if (b >= 0) hits += int'(m[b]);
        @(posedge clk);
        want_evt <= m;
      end
      @(posedge clk);
      want_evt <= '0;
      repeat (3) @(posedge clk);
      rchk(EVCNTR_BASE, 32'(hits), "code count");
    end
    $display("test codes done");
    // overflow with chain, monitor disabled first
    wr(INTENSET_OFF, 32'h1);
    wr(EVTYPER_BASE, 32'h11);
    wr(EVTYPER_BASE + 12'h4, 32'h1e);
    wr(EVTYPER_BASE + 12'h8, 32'h1e);
    wr(EVCNTR_BASE + 12'h4, 32'h5);
    wr(EVCNTR_BASE, 32'hffff);
    wr(CNTENSET_OFF, 32'h7);
    pulse(EVT_BUS_W'(1) << 14, 8'h0);
    chk(32'({trace_pkt.valid, trace_pkt.flags, trigger_evt}), 32'h203, "trace");
    chk(32'({pend, cause}), 32'h0, "pend without monitor");
    rchk(EVCNTR_BASE, 32'h0, "wrap to zero");
    rchk(EVCNTR_BASE + 12'h4, 32'h6, "chain upper");
    rchk(EVCNTR_BASE + 12'h8, 32'h0, "even chain");
    rchk(OVSSET_OFF, 32'h1, "flag set");
    wr(OVSCLR_OFF, 32'h1);
    rchk(OVSSET_OFF, 32'h0, "flag clear");
    wr(DEBUG_CTRL_OFF, 32'h5);
    wr(EVCNTR_BASE, 32'hffff);
    pulse(EVT_BUS_W'(1) << 14, 8'h0);
    chk(32'({pend, cause, halt_req}), 32'h7, "pend cause halt");
    @(posedge clk);
    #1 chk(32'({halt_req, trigger_evt}), 32'h0, "pulses end");
    rchk(OVSSET_OFF, 32'h1, "which counter");
    rchk(DEBUG_CTRL_OFF, 32'hf, "debug ctrl");
    wr(DEBUG_CTRL_OFF, 32'hf);
    rchk(DEBUG_CTRL_OFF, 32'h5, "pend w1c");
    $display("test overflow done");
    // writes make no trace; two rollovers share one packet
    wr(CNTENSET_OFF, 32'h38);
    wr(EVTYPER_BASE + 12'h10, 32'h8);
    wr(EVTYPER_BASE + 12'h14, 32'h8);
    wr(EVCNTR_BASE + 12'h10, 32'hff);
    wr(EVCNTR_BASE + 12'h14, 32'hff);
    wr(EVCNTR_BASE + 12'hc, 32'hff);
    wr(EVCNTR_BASE + 12'hc, 32'h1ff);
    @(posedge clk);
    #1 chk(32'(trace_pkt.valid), 32'h0, "write trace");
    pulse(EVT_BUS_W'(1) << 6, 8'h0);
    chk(32'({trace_pkt.valid, trace_pkt.flags}), 32'h130, "multi flags");
    wr(SWINC_OFF, 32'h8);
    rchk(EVCNTR_BASE + 12'hc, 32'h200, "soft increment");
    $display("test trace done");
    // profiling mode and enable gating
    wr(WATCH_CTRL_OFF, 32'h2);
    wr(EVCNTR_BASE + 12'h18, 32'h0);
    wr(CNTENSET_OFF, 32'h40);
    repeat (3) pulse('0, 8'h40);
    rchk(EVCNTR_BASE + 12'h18, 32'h3, "profiling");
    wr(CNTENCLR_OFF, 32'h40);
    pulse('0, 8'h40);
    rchk(EVCNTR_BASE + 12'h18, 32'h3, "disabled hold");
    rchk(CNTENSET_OFF, 32'h3f, "enable mask");
    $display("test profiling done");
    // cycle counter enabled from either side, crossing 16 bits
    wr(WATCH_CTRL_OFF, 32'h1);
    cyc_diff(rv);
    chk(rv, 32'd12, "watch cycles");
    wr(WATCH_CTRL_OFF, 32'h0);
    wr(CCNTR_OFF, 32'hfff8);
    wr(CNTENSET_OFF, 32'h8000_0000);
    cyc_diff(rv);
    chk(rv, 32'd12, "monitor cycles");
    $display("test cycles done");
    close_out();
  end
endmodule
`default_nettype wire
